// file: rtl/isr_consts.svh
// Constants for the two-wire slave register access block
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH

// ============================================================
// Bus addressing
`define ISR_SLAVE_ADDR 7'h0a
`define ISR_MODE_TWO_WIRE 2'h2
`define ISR_PTR_W 8
`define ISR_ADDR_W 10
`define ISR_DATA_W 32
`define ISR_WORD_W 42

// ============================================================
// Byte and bit counts
`define ISR_LAST_BIT 3'h7
`define ISR_LAST_BYTE 2'h3
`define ISR_STRAP_WAIT 2'h3

`endif

// file: rtl/isr_pkg.sv
// Types shared by the two-wire slave register access block
package isr_pkg;

	typedef enum logic [3:0] {
		ISR_IDLE,
		ISR_ADDR,
		ISR_PTR,
		ISR_WDATA,
		ISR_RDATA,
		ISR_ACK_WAIT,
		ISR_ACK_HOLD,
		ISR_RACK_WAIT,
		ISR_RACK,
		ISR_IGNORE
	} isr_state_e;

	typedef logic [7:0] isr_ptr_t;

endpackage

// file: rtl/isr_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps

module isr_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// ============================================================
	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // isr_sync

// file: rtl/isr_buf.sv
// Two-entry write buffer between the serial side and the register file
`timescale 1ns/1ps

module isr_buf #(
	parameter int W = 42
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	logic hv_q, hv_d, tv_q, tv_d;
	logic [W-1:0] tail_q, tail_d, head_d;
	logic pop, push;

	// ============================================================
	// Head entry is the output so the port comes from a flop
	always_comb begin
		in_ready = ~tv_q;
		pop = hv_q & out_ready;
		push = in_valid & ~tv_q;
		hv_d = hv_q;
		tv_d = tv_q;
		head_d = out_data;
		tail_d = tail_q;
		if (pop) begin
			hv_d = tv_q;
			head_d = tail_q;
			tv_d = 1'b0;
		end
		if (push) begin
			if (!hv_d) begin
				hv_d = 1'b1;
				head_d = in_data;
			end else begin
				tv_d = 1'b1;
				tail_d = in_data;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hv_q <= 1'b0;
			tv_q <= 1'b0;
			out_data <= '0;
			tail_q <= '0;
		end else begin
			hv_q <= hv_d;
			tv_q <= tv_d;
			out_data <= head_d;
			tail_q <= tail_d;
		end
	end

	assign out_valid = hv_q;

endmodule // isr_buf

// file: rtl/isr_slave.sv
// Two-wire slave giving an outside master access to the 32-bit registers
`timescale 1ns/1ps
`include "isr_consts.svh"

// What this block does
// - Slave enabled only when mode strap equals 10b
// - Works with 100 kHz and 400 kHz clocks
// - Match seven address bits, acknowledge, eighth selects direction
// - Mismatch: no acknowledge, ignore until next start
// - Pointer byte alone then start/stop loads pointer
// - Pointer is word index; byte address appends 00
// - Bits and bytes go most significant first
// - Read sends four bytes; single read keeps pointer
// - Fourth byte acked: pointer wraps upward, next register
// - Multiple read increments pointer for every register
// - Nack on bytes one to three stops sending
// - Start or stop mid-read aborts and resynchronises
// - Register snapshot taken before each 32-bit read
// - Clear-on-read only after all 32 bits sent
// - Unused locations read as zero
// - During reset the interface gives no valid data
// - Every write byte acknowledged except a word's fourth byte when the buffer is full; single write keeps pointer
// - Further write bytes advance pointer, including last register
// - Write committed only after full 32 bits
// - Start or stop mid-write abandons, decodes fresh
module isr_slave (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [1:0] mode_strap,
	output logic sda_o,
	output logic sda_oe,
	output logic rd_req,
	output logic [`ISR_ADDR_W-1:0] rd_addr,
	input wire logic rd_ack,
	input wire logic rd_hit,
	input wire logic [`ISR_DATA_W-1:0] rd_data,
	output logic rd_done,
	output logic [`ISR_ADDR_W-1:0] rd_done_addr,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [`ISR_ADDR_W-1:0] wr_addr,
	output logic [`ISR_DATA_W-1:0] wr_data
);

	// ============================================================
	// Helpers
	function automatic isr_pkg::isr_ptr_t ptr_inc(input isr_pkg::isr_ptr_t p);
		ptr_inc = p + 8'h01;
	endfunction

	function automatic logic [`ISR_ADDR_W-1:0] byte_addr(input isr_pkg::isr_ptr_t p);
		byte_addr = {p, 2'h0};
	endfunction

	// ============================================================
	// Pin sampling and line events
	logic [3:0] sy;
	logic scl, sda, scl_p_q, sda_p_q;
	logic rise, fall, start_ev, stop_ev;

	// Sampling at 10 MHz leaves several cycles per fast-mode phase
	isr_sync #(.W(4)) u_sync (
		.clk(mclk),
		.rst(rst),
		.d({mode_strap, scl_i, sda_i}),
		.q(sy)
	);

	assign scl = sy[1];
	assign sda = sy[0];
	assign rise = scl & ~scl_p_q;
	assign fall = ~scl & scl_p_q;
	assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
	assign stop_ev = scl & scl_p_q & ~sda_p_q & sda;

	// ============================================================
	// State
	isr_pkg::isr_state_e st_q, st_d, nxt_q, nxt_d;
	logic [2:0] cnt_q, cnt_d;
	logic [1:0] bi_q, bi_d, cap_q, cap_d;
	logic [7:0] sh_q, sh_d;
	isr_pkg::isr_ptr_t ptr_q, ptr_d;
	logic [`ISR_DATA_W-1:0] snap_q, snap_d, tx_q, tx_d, wacc_q, wacc_d;
	logic en_q, en_d, first_q, first_d, wr1_q, wr1_d, ack_q, ack_d;
	logic oe_d, rdreq_d, done_d;
	logic [`ISR_ADDR_W-1:0] rdaddr_d, doneaddr_d;
	logic [7:0] byte_in;
	logic push, buf_ready;
	logic [`ISR_WORD_W-1:0] push_word;

	assign byte_in = {sh_q[6:0], sda};
	assign push_word = {byte_addr(ptr_q), wacc_q[23:0], byte_in};

	always_comb begin
		st_d = st_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		bi_d = bi_q;
		cap_d = cap_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		snap_d = snap_q;
		tx_d = tx_q;
		wacc_d = wacc_q;
		en_d = en_q;
		first_d = first_q;
		wr1_d = wr1_q;
		ack_d = ack_q;
		oe_d = sda_oe;
		rdreq_d = 1'b0;
		rdaddr_d = rd_addr;
		done_d = 1'b0;
		doneaddr_d = rd_done_addr;
		push = 1'b0;

		// Strap caught once, after the synchroniser has filled
		if (cap_q != `ISR_STRAP_WAIT) begin
			cap_d = cap_q + 2'h1;
			if (cap_d == `ISR_STRAP_WAIT) begin
				en_d = (sy[3:2] == `ISR_MODE_TWO_WIRE);
			end
		end

		// Snapshot arrives from the register file
		if (rd_ack) begin
			snap_d = rd_hit ? rd_data : '0;
		end

		if (!en_q) begin
			st_d = isr_pkg::ISR_IDLE;
		end else if (start_ev) begin
			st_d = isr_pkg::ISR_ADDR;
			cnt_d = 3'h0;
			oe_d = 1'b0;
		end else if (stop_ev) begin
			st_d = isr_pkg::ISR_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				isr_pkg::ISR_ADDR, isr_pkg::ISR_PTR, isr_pkg::ISR_WDATA: begin
					if (rise) begin
						sh_d = byte_in;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == `ISR_LAST_BIT) begin
							st_d = isr_pkg::ISR_ACK_WAIT;
							ack_d = 1'b1;
							if (st_q == isr_pkg::ISR_ADDR) begin
								if (sh_q[6:0] == `ISR_SLAVE_ADDR) begin
									nxt_d = sda ? isr_pkg::ISR_RDATA : isr_pkg::ISR_PTR;
									bi_d = 2'h0;
									first_d = 1'b1;
									if (sda) begin
										rdreq_d = 1'b1;
										rdaddr_d = byte_addr(ptr_q);
									end
								end else begin
									st_d = isr_pkg::ISR_IGNORE;
								end
							end else if (st_q == isr_pkg::ISR_PTR) begin
								ptr_d = byte_in;
								nxt_d = isr_pkg::ISR_WDATA;
								bi_d = 2'h0;
								first_d = 1'b1;
								wr1_d = 1'b0;
							end else begin
								nxt_d = isr_pkg::ISR_WDATA;
								wacc_d = {wacc_q[23:0], byte_in};
								bi_d = bi_q + 2'h1;
								if (bi_q == `ISR_LAST_BYTE) begin
									if (buf_ready) begin
										push = 1'b1;
										if (first_q) begin
											wr1_d = 1'b1;
										end else begin
											ptr_d = ptr_inc(ptr_q);
										end
									end else begin
										// Buffer full: refuse the word rather than lose it
										st_d = isr_pkg::ISR_IGNORE;
									end
								end else if (bi_q == 2'h0 && first_q && wr1_q) begin
									ptr_d = ptr_inc(ptr_q);
									first_d = 1'b0;
								end
							end
						end
					end
				end
				isr_pkg::ISR_ACK_WAIT: begin
					if (fall) begin
						oe_d = ack_q;
						st_d = isr_pkg::ISR_ACK_HOLD;
					end
				end
				isr_pkg::ISR_ACK_HOLD: begin
					if (fall) begin
						st_d = nxt_q;
						cnt_d = 3'h0;
						oe_d = 1'b0;
						if (nxt_q == isr_pkg::ISR_RDATA) begin
							tx_d = snap_q;
							oe_d = ~snap_q[31];
						end
					end
				end
				isr_pkg::ISR_RDATA: begin
					if (fall) begin
						oe_d = ~tx_q[31];
					end else if (rise) begin
						tx_d = {tx_q[30:0], 1'b0};
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == `ISR_LAST_BIT) begin
							st_d = isr_pkg::ISR_RACK_WAIT;
							if (bi_q == `ISR_LAST_BYTE) begin
								// Prefetch so the next word is ready for its first bit
								rdreq_d = 1'b1;
								rdaddr_d = byte_addr(ptr_inc(ptr_q));
							end
						end
					end
				end
				isr_pkg::ISR_RACK_WAIT: begin
					if (fall) begin
						oe_d = 1'b0;
						st_d = isr_pkg::ISR_RACK;
					end
				end
				isr_pkg::ISR_RACK: begin
					if (rise) begin
						bi_d = bi_q + 2'h1;
						if (bi_q == `ISR_LAST_BYTE) begin
							done_d = 1'b1;
							doneaddr_d = byte_addr(ptr_q);
						end
						if (!sda) begin
							st_d = isr_pkg::ISR_RDATA;
							if (bi_q == `ISR_LAST_BYTE) begin
								ptr_d = ptr_inc(ptr_q);
								first_d = 1'b0;
								tx_d = snap_q;
							end
						end else begin
							st_d = isr_pkg::ISR_IGNORE;
							if (bi_q == `ISR_LAST_BYTE && !first_q) begin
								ptr_d = ptr_inc(ptr_q);
							end
						end
					end
				end
				isr_pkg::ISR_IGNORE: begin
					oe_d = 1'b0;
				end
				isr_pkg::ISR_IDLE: begin
					oe_d = 1'b0;
				end
				default: begin
					st_d = isr_pkg::ISR_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Everything idles and releases the line while reset is held
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q <= isr_pkg::ISR_IDLE;
			nxt_q <= isr_pkg::ISR_IDLE;
			cnt_q <= 3'h0;
			bi_q <= 2'h0;
			cap_q <= 2'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			snap_q <= '0;
			tx_q <= '0;
			wacc_q <= '0;
			en_q <= 1'b0;
			first_q <= 1'b0;
			wr1_q <= 1'b0;
			ack_q <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
			rd_req <= 1'b0;
			rd_addr <= '0;
			rd_done <= 1'b0;
			rd_done_addr <= '0;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
			st_q <= st_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			bi_q <= bi_d;
			cap_q <= cap_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			snap_q <= snap_d;
			tx_q <= tx_d;
			wacc_q <= wacc_d;
			en_q <= en_d;
			first_q <= first_d;
			wr1_q <= wr1_d;
			ack_q <= ack_d;
			sda_o <= 1'b0;
			sda_oe <= oe_d;
			rd_req <= rdreq_d;
			rd_addr <= rdaddr_d;
			rd_done <= done_d;
			rd_done_addr <= doneaddr_d;
		end
	end

	// ============================================================
	// Committed writes wait here while the register file is busy
	isr_buf #(.W(`ISR_WORD_W)) u_buf (
		.clk(mclk),
		.rst(rst),
		.in_valid(push),
		.in_ready(buf_ready),
		.in_data(push_word),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data({wr_addr, wr_data})
	);

endmodule // isr_slave

// file: testbench/isr_chk.sv
// Port assertions for the two-wire slave
`timescale 1ns/1ps
`include "isr_consts.svh"

module isr_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic rd_req,
	input wire logic [`ISR_ADDR_W-1:0] rd_addr,
	input wire logic rd_done,
	input wire logic [`ISR_ADDR_W-1:0] rd_done_addr,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [`ISR_ADDR_W-1:0] wr_addr,
	input wire logic [`ISR_DATA_W-1:0] wr_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ============================================================
	// Sequences
	sequence stop_cond;
		scl_i && $rose(sda_i);
	endsequence
	sequence one_req;
		rd_req ##1 !rd_req;
	endsequence

	// ============================================================
	// Properties
	a_sda_pull_only: assert property (sda_o == 1'b0) else $error("sda_o driven high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("sda_oe moved while scl high");
	a_stop_release: assert property (stop_cond |=> !sda_oe [*8])
		else $error("sda driven after stop");
	a_req_pulse: assert property (rd_req |-> one_req)
		else $error("rd_req wider than one cycle");
	a_req_word: assert property (rd_req |-> rd_addr[1:0] == 2'h0)
		else $error("rd_addr not word aligned");
	// Request address must stand between requests
	a_addr_stands: assert property ($changed(rd_addr) |-> rd_req)
		else $error("rd_addr moved without a request");
	a_done_pulse: assert property (rd_done |=> !rd_done)
		else $error("rd_done wider than one");
	// Next word is always prefetched before the finished one is reported
	a_done_word: assert property (rd_done |-> rd_done_addr[1:0] == 2'h0
		&& rd_done_addr == rd_addr - 10'h4) else $error("rd_done_addr not behind the prefetch");
	a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr)
		&& $stable(wr_data)) else $error("write word dropped while stalled");
endmodule // isr_chk

// file: testbench/isr_master.sv
// Bus master model for the two-wire link
`timescale 1ns/1ps

module isr_master (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// ============================================================
	// Conditions and bits, 4 mclk low and 4 high
	task automatic start();
		sda_low = 1'b0;
		hold(2);
		scl = 1'b1;
		hold(4);
		sda_low = 1'b1;
		hold(4);
		scl = 1'b0;
		hold(2);
	endtask

	task automatic stop();
		sda_low = 1'b1;
		hold(2);
		scl = 1'b1;
		hold(4);
		sda_low = 1'b0;
		hold(4);
	endtask

	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		hold(2);
		scl = 1'b1;
		hold(3);
		r = sda;
		hold(1);
		scl = 1'b0;
		hold(2);
	endtask

	task automatic wbyte(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r);
		end
		bitx(1'b1, nak);
	endtask

	task automatic rbyte(input logic nak, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, b[i]);
		end
		bitx(nak, r);
	endtask
endmodule // isr_master

// file: testbench/tb_isr_slave.sv
// Testbench for the two-wire slave register access block
`timescale 1ns/1ps
`include "isr_consts.svh"

module tb_isr_slave;
	typedef struct {logic [7:0] p; logic [31:0] v;} isr_row_s;
	logic mclk, rst, scl, sda, sda_low, sda_o, sda_oe, ak;
	logic rd_req, rd_ack, rd_hit, rd_done, wr_valid, wr_ready;
	logic [1:0] mode_strap;
	logic [`ISR_ADDR_W-1:0] rd_addr, rd_done_addr, wr_addr;
	logic [31:0] rd_data, wr_data, d;
	logic [31:0] mem [256];
	int fails, checked, cyc, wcnt, n0;
	isr_row_s rows [3] = '{'{8'h00, 32'h80000001}, '{8'h12, 32'ha5c30ff0},
		'{8'h7e, 32'hffffffff}};

	// Pull-up on the data line
	assign sda = (sda_oe ? sda_o : 1'b1) & !sda_low;

	isr_slave i_isr_slave (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda),
		.mode_strap(mode_strap), .sda_o(sda_o), .sda_oe(sda_oe), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_ack(rd_ack), .rd_hit(rd_hit), .rd_data(rd_data),
		.rd_done(rd_done), .rd_done_addr(rd_done_addr), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
	isr_master i_isr_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = !mclk;
	end

	// ============================================================
	// Register file; word 7f clears on a completed read
	always @(posedge mclk) begin
		rd_ack <= rd_req;
		rd_hit <= rd_addr < 10'h200;
		rd_data <= mem[rd_addr[9:2]];
		if (wr_valid && wr_ready) begin
			mem[wr_addr[9:2]] <= wr_data;
			wcnt <= wcnt + 1;
		end
		if (rd_done && rd_done_addr == 10'h1fc) mem[8'h7f] <= '0;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	// ============================================================
	// Tasks
	task automatic stop_test();
		if (fails == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic ctl(input logic [7:0] c, input logic nk);
		i_isr_master.start();
		i_isr_master.wbyte(c, ak);
		chk("control ack", {31'h0, nk}, {31'h0, ak});
	endtask

	task automatic wr(input logic [7:0] b, input logic nk);
		i_isr_master.wbyte(b, ak);
		chk("write ack", {31'h0, nk}, {31'h0, ak});
	endtask

	task automatic rdw(input logic nk, output logic [31:0] v);
		for (int i = 3; i >= 0; i--) begin
			i_isr_master.rbyte(i == 0 ? nk : 1'b0, v[i*8+:8]);
		end
	endtask

	task automatic rdx(input logic [31:0] e);
		ctl(8'h15, 1'b0);
		rdw(1'b1, d);
		i_isr_master.stop();
		chk("read data", e, d);
	endtask

	initial begin
		rst = 1'b1;
		mode_strap = 2'h2;
		{rd_ack, rd_hit, rd_data, wr_ready} = '0;
		{fails, checked, cyc, wcnt} = '0;
		for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0], i[7:0], 8'h3c};
		repeat (6) @(negedge mclk);
		chk("reset outputs", 32'h0, {sda_oe, rd_req, rd_done, wr_valid});
		rst = 1'b0;
		wr_ready = 1'b1;
		repeat (6) @(negedge mclk);
		foreach (rows[i]) begin
			ctl(8'h14, 1'b0);
			wr(rows[i].p, 1'b0);
			for (int k = 3; k >= 0; k--) wr(rows[i].v[k*8+:8], 1'b0);
			i_isr_master.stop();
			rdx(rows[i].v);
			rdx(rows[i].v);
		end
		// ============================================================
		// Pointer only, then burst across the wrap
		ctl(8'h14, 1'b0);
		wr(8'hff, 1'b0);
		i_isr_master.stop();
		ctl(8'h15, 1'b0);
		rdw(1'b0, d);
		chk("unmapped read", 32'h0, d);
		rdw(1'b1, d);
		i_isr_master.stop();
		chk("wrapped read", rows[0].v, d);
		rdx(32'h01fe013c);
		// ============================================================
		// Early nack and a mid-word stop leave the clear-on-read word alone
		ctl(8'h14, 1'b0);
		wr(8'h7f, 1'b0);
		i_isr_master.stop();
		ctl(8'h15, 1'b0);
		i_isr_master.rbyte(1'b1, d[7:0]);
		i_isr_master.rbyte(1'b1, d[7:0]);
		i_isr_master.stop();
		chk("released after nack", 32'hff, {24'h0, d[7:0]});
		// Second byte opens with a one, so the line is free for the stop
		ctl(8'h15, 1'b0);
		i_isr_master.rbyte(1'b0, d[7:0]);
		i_isr_master.stop();
		chk("byte before stop", 32'h7f, {24'h0, d[7:0]});
		rdx(32'h7f807f3c);
		rdx(32'h0);
		ctl(8'h16, 1'b1);
		wr(8'h00, 1'b1);
		i_isr_master.stop();
		// ============================================================
		// Write cut by a repeated start
		n0 = wcnt;
		ctl(8'h14, 1'b0);
		wr(8'h20, 1'b0);
		wr(8'h11, 1'b0);
		wr(8'h22, 1'b0);
		ctl(8'h15, 1'b0);
		rdw(1'b1, d);
		i_isr_master.stop();
		chk("fresh read", 32'h20df203c, d);
		chk("cut write", n0, wcnt);
		// ============================================================
		// Stalled register file fills the buffer
		wr_ready = 1'b0;
		n0 = wcnt;
		ctl(8'h14, 1'b0);
		wr(8'h30, 1'b0);
		for (int w = 0; w < 3; w++) begin
			for (int k = 0; k < 4; k++) wr(8'h40 + 8'(w), w == 2 && k == 3);
		end
		i_isr_master.stop();
		wr_ready = 1'b1;
		repeat (10) @(negedge mclk);
		chk("buffered writes", n0 + 2, wcnt);
		// Pointer moved past both committed words, not the refused one
		rdx(32'h32cd323c);
		ctl(8'h14, 1'b0);
		wr(8'h31, 1'b0);
		i_isr_master.stop();
		rdx(32'h41414141);
		// Wrong strap keeps the slave deaf
		rst = 1'b1;
		mode_strap = 2'h1;
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		repeat (6) @(negedge mclk);
		ctl(8'h14, 1'b1);
		i_isr_master.stop();
		stop_test();
	end
endmodule // tb_isr_slave

bind isr_slave isr_chk i_isr_chk (.mclk(mclk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .rd_req(rd_req), .rd_addr(rd_addr), .rd_done(rd_done),
	.rd_done_addr(rd_done_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
	.wr_addr(wr_addr), .wr_data(wr_data));
